// *** hdl/fpcl_regs.vh ***
// How it works
// - In user mode the trigger, ready and load-complete lines idle high; a low trigger restarts configuration.
// - After power-up the ready line is held low for the whole power-on delay.
// - The load-complete line stays low from power-up until all configuration data is in.
// - After configuration the config clock is ignored; the host keeps it at a defined level.
// - Load-complete is released only once the whole bitstream arrived without error.
// - With the startup-finished option loaded, that pin is driven low until initialization ends.
// - Within 600 ns of the trigger falling, load-complete and ready are both driven low.
// - Ready is held low 268 to 1506 us and rises within 1506 us of the trigger returning high.
// - With the internal oscillator, user mode comes 175 to 437 us after load-complete rises.
// - With user-clock init, that clock is enabled 4 max config periods after load-complete, then 8576 periods follow.
`ifndef FPCL_REGS_VH
`define FPCL_REGS_VH

// ==========================================
// Clock and timing
`define FPCL_CLK_MHZ        50
`define FPCL_POR_US         100
`define FPCL_POR_CYC        (`FPCL_POR_US * `FPCL_CLK_MHZ)
`define FPCL_STAT_MIN_US    268
`define FPCL_STAT_CYC       (`FPCL_STAT_MIN_US * `FPCL_CLK_MHZ)
`define FPCL_INIT_MIN_US    175
`define FPCL_INIT_CYC       (`FPCL_INIT_MIN_US * `FPCL_CLK_MHZ)
`define FPCL_UCLK_WAIT_NS   40
`define FPCL_UCLK_WAIT_CYC  ((`FPCL_UCLK_WAIT_NS * `FPCL_CLK_MHZ + 999) / 1000)
`define FPCL_UINIT_PERIODS  8576
`define FPCL_DONE_FALLS     2'h2

// ==========================================
// Bus width codes and buffer shape
`define FPCL_W8             2'h0
`define FPCL_W16            2'h1
`define FPCL_W32            2'h2
`define FPCL_FIFO_WIDTH     32
`define FPCL_FIFO_DEPTH     8
`define FPCL_FIFO_AW        3

`endif

// *** hdl/fpcl_fifo.v ***
`timescale 1ns/1ps
`include "fpcl_regs.vh"

module fpcl_fifo #(
  parameter WIDTH = `FPCL_FIFO_WIDTH,
  parameter DEPTH = `FPCL_FIFO_DEPTH,
  parameter AW    = `FPCL_FIFO_AW
) (
  // Clock, reset, flush
  input  wire             clk,
  input  wire             sys_rst,
  input  wire             clear,
  // Fill side
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  // Drain side
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);

  localparam [AW:0] FULL_CNT = DEPTH;

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wrIdx_reg;
  reg [AW-1:0]    rdIdx_reg;
  reg [AW:0]      count_reg;
  wire            push;
  wire            pop;

  // Full and empty come from the fill count, not from pointer compare
  assign inReady  = (count_reg != FULL_CNT);
  assign outValid = (count_reg != {(AW+1){1'b0}});
  assign outData  = mem_reg[rdIdx_reg];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  // Storage is plain flops; no reset needed on data
  always @(posedge clk) begin
    if (push) begin
      mem_reg[wrIdx_reg] <= inData;
    end
  end

  // Pointers and count
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrIdx_reg <= {AW{1'b0}};
      rdIdx_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else if (clear) begin
      wrIdx_reg <= {AW{1'b0}};
      rdIdx_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wrIdx_reg <= wrIdx_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rdIdx_reg <= rdIdx_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule

// *** hdl/fpcl_loader.v ***
`timescale 1ns/1ps
`include "fpcl_regs.vh"

module fpcl_loader #(
  parameter [23:0] POR_CYC   = `FPCL_POR_CYC,
  parameter [23:0] STAT_CYC  = `FPCL_STAT_CYC,
  parameter [23:0] INIT_CYC  = `FPCL_INIT_CYC,
  parameter [15:0] UINIT_CNT = `FPCL_UINIT_PERIODS
) (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // Host driven pins
  input  wire        cfgTrigN,
  input  wire        configClock,
  input  wire        userInitClock,
  input  wire [31:0] cfgData,
  // Ready line, open drain
  input  wire        readyIn,
  output wire        readyOut,
  output wire        readyOe,
  // Load-complete line, open drain
  input  wire        loadDoneIn,
  output wire        loadDoneOut,
  output wire        loadDoneOe,
  // Startup finished pin, open drain
  output wire        initDoneOut,
  output wire        initDoneOe,
  // Data pins handed to user logic
  output wire        dataUserIo,
  // Option straps
  input  wire [1:0]  busWidth,
  input  wire [1:0]  ratioLog,
  input  wire        initDoneEn,
  input  wire        userInitSel,
  input  wire [23:0] streamWords,
  // Configuration word sink
  output wire [31:0] cfgWord,
  output wire        cfgWordValid,
  input  wire        cfgWordReady,
  // Status
  output wire        userMode,
  output wire        loadError
);

  // ==========================================
  // States and sync layout
  localparam [2:0] ST_POR  = 3'h0;
  localparam [2:0] ST_RST  = 3'h1;
  localparam [2:0] ST_STAT = 3'h2;
  localparam [2:0] ST_CFG  = 3'h3;
  localparam [2:0] ST_DONE = 3'h4;
  localparam [2:0] ST_INIT = 3'h5;
  localparam [2:0] ST_USER = 3'h6;
  localparam [2:0] ST_ERR  = 3'h7;
  localparam       I_TRIG  = 36;
  localparam       I_CCLK  = 35;
  localparam       I_UCLK  = 34;
  localparam       I_RDY   = 33;
  localparam       I_LDONE = 32;

  // Keep only the lanes the bus width uses
  function [31:0] fpcl_mask;
    input [31:0] d;
    input [1:0]  w;
    begin
      case (w)
        `FPCL_W8:  fpcl_mask = {24'h000000, d[7:0]};
        `FPCL_W16: fpcl_mask = {16'h0000, d[15:0]};
        default:   fpcl_mask = d;
      endcase
    end
  endfunction

  reg  [36:0] sync1_reg;
  reg  [36:0] sync2_reg;
  reg  [36:0] sync3_reg;
  reg  [36:0] lvl_reg;
  wire [36:0] lvl_next;
  wire [36:0] rise;
  wire [36:0] fall;
  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [23:0] timer_reg;
  reg  [2:0]  phase_reg;
  reg  [1:0]  width_reg;
  reg  [2:0]  phaseMax_reg;
  reg  [23:0] words_reg;
  reg  [1:0]  falls_reg;
  reg  [15:0] uclkCnt_reg;
  reg         initOpt_reg;
  reg         userOpt_reg;
  reg         readyOe_reg;
  reg         loadDoneOe_reg;
  reg         initDoneOe_reg;
  reg         userIo_reg;
  reg         error_reg;
  reg         pinLow_reg;
  reg  [31:0] word_reg;
  reg         wordValid_reg;
  wire        latch;
  wire        fifoInReady;
  wire        fifoOutValid;
  wire [31:0] fifoOutData;
  wire        fifoPop;
  wire        allIn;
  wire        uclkOn;

  // ==========================================
  // Pin synchronisers, three stages
  // A change counts only once stages two and three agree, so a glitch is not an edge
  assign lvl_next = (sync2_reg & ~(sync2_reg ^ sync3_reg)) | (lvl_reg & (sync2_reg ^ sync3_reg));
  assign rise     = lvl_next & ~lvl_reg;
  assign fall     = ~lvl_next & lvl_reg;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_reg <= 37'h1f_0000_0000;
      sync2_reg <= 37'h1f_0000_0000;
      sync3_reg <= 37'h1f_0000_0000;
      lvl_reg   <= 37'h1f_0000_0000;
    end else begin
      sync1_reg <= {cfgTrigN, configClock, userInitClock, readyIn, loadDoneIn, cfgData};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      lvl_reg   <= lvl_next;
    end
  end

  // ==========================================
  // Word capture and completion
  // first edge of each word
  assign latch  = (state_reg == ST_CFG) & lvl_reg[I_RDY] & rise[I_CCLK] &
                  (phase_reg == 3'h0) & (words_reg != streamWords);
  assign allIn  = (words_reg == streamWords) & ~fifoOutValid & ~wordValid_reg;
  assign uclkOn = userOpt_reg & (timer_reg >= `FPCL_UCLK_WAIT_CYC);
  assign fifoPop = fifoOutValid & (~wordValid_reg | cfgWordReady);

  // Next state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_POR: begin
        // hold ready low for power-on delay
        if (timer_reg >= POR_CYC) begin
          state_next = ST_CFG;
        end
      end
      ST_RST: begin
        if (lvl_reg[I_TRIG]) begin
          state_next = ST_STAT;
        end
      end
      ST_STAT: begin
        // release at the minimum low time
        if (timer_reg >= STAT_CYC) begin
          state_next = ST_CFG;
        end
      end
      ST_CFG: begin
        // Host cannot be stalled, so a full buffer is a load error
        if (latch && !fifoInReady) begin
          state_next = ST_ERR;
        end else if (allIn) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        if (falls_reg == `FPCL_DONE_FALLS) begin
          state_next = ST_INIT;
        end
      end
      ST_INIT: begin
        if (!userOpt_reg && timer_reg >= INIT_CYC) begin
          state_next = ST_USER;
        end else if (userOpt_reg && uclkCnt_reg >= UINIT_CNT) begin
          state_next = ST_USER;
        end
      end
      ST_USER: state_next = ST_USER;
      ST_ERR:  state_next = ST_ERR;
      default: state_next = ST_POR;
    endcase
    // low trigger restarts from anywhere past power-on
    if (!lvl_reg[I_TRIG] && state_reg != ST_POR) begin
      state_next = ST_RST;
    end
  end

  // ==========================================
  // Sequencer registers
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg      <= ST_POR;
      timer_reg      <= 24'h000000;
      phase_reg      <= 3'h0;
      width_reg      <= `FPCL_W8;
      phaseMax_reg   <= 3'h0;
      words_reg      <= 24'h000000;
      falls_reg      <= 2'h0;
      uclkCnt_reg    <= 16'h0000;
      initOpt_reg    <= 1'b0;
      userOpt_reg    <= 1'b0;
      readyOe_reg    <= 1'b1;
      loadDoneOe_reg <= 1'b1;
      initDoneOe_reg <= 1'b0;
      userIo_reg     <= 1'b0;
      error_reg      <= 1'b0;
      pinLow_reg     <= 1'b0;
    end else begin
      state_reg <= state_next;
      // Timer restarts on every state change and saturates
      if (state_next != state_reg) begin
        timer_reg <= 24'h000000;
      end else if (~&timer_reg) begin
        timer_reg <= timer_reg + 24'h000001;
      end
      // Straps except streamWords are taken in power-on and while the trigger is low, steady for the whole load
      if (state_reg == ST_RST || state_reg == ST_POR) begin
        width_reg    <= busWidth;
        phaseMax_reg <= (3'h1 << ratioLog) - 3'h1;
        initOpt_reg  <= initDoneEn;
        userOpt_reg  <= userInitSel;
        words_reg    <= 24'h000000;
        phase_reg    <= 3'h0;
      end
      if (state_reg == ST_CFG && lvl_reg[I_RDY] && rise[I_CCLK]) begin
        phase_reg <= (phase_reg == phaseMax_reg) ? 3'h0 : phase_reg + 3'h1;
      end
      if (latch && fifoInReady) begin
        words_reg <= words_reg + 24'h000001;
      end
      // count falling edges once the line is really high
      if (state_reg != ST_DONE) begin
        falls_reg <= 2'h0;
      end else if (lvl_reg[I_LDONE] && fall[I_CCLK]) begin
        falls_reg <= falls_reg + 2'h1;
      end
      // user clock enabled only after the wait
      if (state_reg != ST_DONE && state_reg != ST_INIT) begin
        uclkCnt_reg <= 16'h0000;
      end else if (uclkOn && rise[I_UCLK] && ~&uclkCnt_reg) begin
        uclkCnt_reg <= uclkCnt_reg + 16'h0001;
      end
      // ready low on trigger, hold it
      readyOe_reg <= (state_next == ST_POR) | (state_next == ST_RST) |
                     (state_next == ST_STAT) | (state_next == ST_ERR);
      // load-complete low until the load is done
      loadDoneOe_reg <= (state_next != ST_DONE) & (state_next != ST_INIT) &
                        (state_next != ST_USER);
      // startup pin low until init ends
      initDoneOe_reg <= initOpt_reg & ((state_next == ST_DONE) | (state_next == ST_INIT));
      // data pins released in user mode
      userIo_reg <= (state_next == ST_USER);
      error_reg  <= (state_next == ST_ERR);
      pinLow_reg <= 1'b0;
    end
  end

  // ==========================================
  // Word buffer and output stage
  fpcl_fifo #(
    .WIDTH (`FPCL_FIFO_WIDTH),
    .DEPTH (`FPCL_FIFO_DEPTH),
    .AW    (`FPCL_FIFO_AW)
  ) u_fifo (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .clear    (state_reg == ST_RST),
    .inValid  (latch),
    .inReady  (fifoInReady),
    .inData   (fpcl_mask(lvl_reg[31:0], width_reg)),
    .outValid (fifoOutValid),
    .outReady (~wordValid_reg | cfgWordReady),
    .outData  (fifoOutData)
  );

  // Registered head so the sink sees flop outputs
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      word_reg      <= 32'h00000000;
      wordValid_reg <= 1'b0;
    end else if (state_reg == ST_RST) begin
      wordValid_reg <= 1'b0;
    end else if (fifoPop) begin
      word_reg      <= fifoOutData;
      wordValid_reg <= 1'b1;
    end else if (cfgWordReady) begin
      wordValid_reg <= 1'b0;
    end
  end

  // ==========================================
  // Outputs
  // config clock is only looked at in load and done states
  assign readyOut     = pinLow_reg;
  assign readyOe      = readyOe_reg;
  assign loadDoneOut  = pinLow_reg;
  assign loadDoneOe   = loadDoneOe_reg;
  assign initDoneOut  = pinLow_reg;
  assign initDoneOe   = initDoneOe_reg;
  assign dataUserIo   = userIo_reg;
  assign cfgWord      = word_reg;
  assign cfgWordValid = wordValid_reg;
  assign userMode     = userIo_reg;
  assign loadError    = error_reg;

endmodule

// *** tb/fpcl_loader_props.sv ***
`timescale 1ns/1ps
// ======
// Pin checks of the loader
module fpcl_loader_props #(
  parameter [23:0] STAT_CYC  = 24'h1e,
  parameter [23:0] INIT_CYC  = 24'h28,
  parameter [15:0] UINIT_CNT = 16'h4
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Pins and straps
  input wire cfgTrigN,
  input wire userInitClock,
  input wire initDoneEn,
  input wire userInitSel,
  // Device outputs
  input wire readyOe,
  input wire loadDoneOe,
  input wire initDoneOe,
  input wire dataUserIo,
  input wire userMode,
  input wire loadError
);
  localparam int MAXST = STAT_CYC * 1506 / 268;
  localparam int MAXIN = INIT_CYC * 437 / 175;
  reg [23:0] sinceTrig, sinceDone;
  reg [15:0] userEdges;
  reg        trigSeen, ucPrev;
  // Time since trigger and load-complete release; edges counted by sampling
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sinceTrig <= 24'h0;
      sinceDone <= 24'h0;
      userEdges <= 16'h0;
      trigSeen  <= 1'b0;
      ucPrev    <= 1'b0;
    end else begin
      sinceTrig <= cfgTrigN ? sinceTrig + 24'h1 : 24'h0;
      sinceDone <= loadDoneOe ? 24'h0 : sinceDone + 24'h1;
      userEdges <= loadDoneOe ? 16'h0 : userEdges + {15'h0, userInitClock & ~ucPrev};
      trigSeen  <= trigSeen | ~cfgTrigN;
      ucPrev    <= userInitClock;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Properties, one per rule on the device side
  property p_por; $fell(sys_rst) |-> (readyOe && loadDoneOe) [*8]; endproperty
  property p_trig; $fell(cfgTrigN) && userMode |-> ##[1:30] (readyOe && loadDoneOe); endproperty
  property p_idle; userMode |-> !readyOe && !loadDoneOe; endproperty
  property p_clean; $fell(loadDoneOe) |-> !loadError && !readyOe; endproperty
  property p_stat;
    $fell(readyOe) && trigSeen |-> sinceTrig >= STAT_CYC && sinceTrig <= MAXST;
  endproperty
  property p_iint;
    $rose(userMode) && !userInitSel |-> sinceDone + 24'h2 >= INIT_CYC && sinceDone <= MAXIN;
  endproperty
  property p_iusr; $rose(userMode) && userInitSel |-> userEdges >= UINIT_CNT; endproperty
  property p_ipin; $rose(userMode) && initDoneEn |-> $past(initDoneOe); endproperty
  property p_irel; $fell(initDoneOe) |-> userMode; endproperty
  property p_uio; dataUserIo == userMode; endproperty
  a_por: assert property (p_por) else $error("lines released in power-up");
  a_trig: assert property (p_trig) else $error("trigger not answered");
  a_idle: assert property (p_idle) else $error("line low in user mode");
  a_clean: assert property (p_clean) else $error("load-complete after error");
  a_stat: assert property (p_stat) else $error("ready low time out of range");
  a_iint: assert property (p_iint) else $error("internal init time wrong");
  a_iusr: assert property (p_iusr) else $error("user clock init too short");
  a_ipin: assert property (p_ipin) else $error("startup pin not held low");
  a_irel: assert property (p_irel) else $error("startup pin released early");
  a_uio: assert property (p_uio) else $error("data pins not handed over");
  c_user: cover property ($rose(userMode));
  c_err: cover property ($rose(loadError));
  c_done: cover property ($fell(loadDoneOe));
endmodule

bind fpcl_loader fpcl_loader_props #(.STAT_CYC(STAT_CYC), .INIT_CYC(INIT_CYC),
  .UINIT_CNT(UINIT_CNT)) i_fpcl_loader_props (.*);

// *** tb/fpcl_host.sv ***
`timescale 1ns/1ps
// ======
// Configuration host model
module fpcl_host (
  // Clock
  input  wire        clk,
  // Pins driven toward the device
  output reg         cfgTrigN,
  output reg         configClock,
  output reg  [31:0] cfgData,
  // Open-drain lines as seen on the wire
  input  wire        readyLine,
  input  wire        loadDoneLine
);
  integer i;
  // Idle levels at time zero; config clock stands low outside frames
  initial begin
    cfgTrigN = 1'b1;
    configClock = 1'b0;
    cfgData = 32'h0;
  end
  task tick;
    begin
      configClock <= 1'b1;
      repeat (4) @(posedge clk);
      configClock <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  task restart;
    begin
      cfgTrigN <= 1'b0;
      repeat (100) @(posedge clk);
      cfgTrigN <= 1'b1;
      i = 0;
      while (!readyLine && i < 2000) begin
        @(posedge clk);
        i = i + 1;
      end
      repeat (100) @(posedge clk);
    end
  endtask
  task send(input [31:0] d, input [3:0] n);
    begin
      cfgData <= d;
      // Word settles one clk before the rising edge that it is taken on
      @(posedge clk);
      for (i = 0; i < n; i = i + 1)
        tick;
    end
  endtask
  task finish(input [3:0] n);
    begin
      for (i = 1; i < n; i = i + 1)
        tick;
      cfgData <= ~cfgData;
      i = 0;
      while (!loadDoneLine && i < 600) begin
        @(posedge clk);
        i = i + 1;
      end
      tick;
      tick;
    end
  endtask
endmodule

// *** tb/fpcl_loader_tb.sv ***
`timescale 1ns/1ps
// ======
// Loader bench: reset, then table rows, overflow and mid-run reset
module fpcl_loader_tb;
  logic        clk = 1'b0, sys_rst = 1'b1, userInitClock = 1'b0, cfgWordReady = 1'b0;
  logic        initDoneEn = 1'b0, userInitSel = 1'b0, stallOn = 1'b0, holdSink = 1'b0;
  logic [1:0]  busWidth = 2'h0, ratioLog = 2'h0;
  logic [2:0]  ucDiv = 3'h0;
  logic [23:0] streamWords = 24'h2;
  logic [31:0] mask;
  logic [31:0] got [$];
  logic [69:0] row;
  integer      miscompares = 0, nCompared = 0, cycles = 0, r, k;
  wire         cfgTrigN, configClock, readyOut, readyOe, loadDoneOut, loadDoneOe;
  wire         initDoneOut, initDoneOe, dataUserIo, cfgWordValid, userMode, loadError;
  wire  [31:0] cfgData, cfgWord;
  wire         readyLine = readyOe ? readyOut : 1'b1;
  wire         loadDoneLine = loadDoneOe ? loadDoneOut : 1'b1;
  // Width, ratio log, user-clock init, pin option, data, expected first word
  logic [69:0] rows [4] = '{
    {2'h0, 2'h1, 1'b0, 1'b1, 32'h1234_5678, 32'h0000_0078},
    {2'h1, 2'h2, 1'b1, 1'b0, 32'hcafe_f00d, 32'h0000_f00d},
    {2'h2, 2'h3, 1'b0, 1'b1, 32'h89ab_cdef, 32'h89ab_cdef},
    {2'h3, 2'h0, 1'b1, 1'b1, 32'h5a5a_a5a5, 32'h5a5a_a5a5}};
  always #10 clk = ~clk;
  fpcl_host i_fpcl_host (.clk(clk), .cfgTrigN(cfgTrigN), .configClock(configClock),
    .cfgData(cfgData), .readyLine(readyLine), .loadDoneLine(loadDoneLine));
  // Long delays shortened so a run stays brief
  fpcl_loader #(.POR_CYC(24'h14), .STAT_CYC(24'h1e), .INIT_CYC(24'h28), .UINIT_CNT(16'h4))
  i_fpcl_loader (.clk(clk), .sys_rst(sys_rst), .cfgTrigN(cfgTrigN),
    .configClock(configClock), .userInitClock(userInitClock), .cfgData(cfgData),
    .readyIn(readyLine), .readyOut(readyOut), .readyOe(readyOe),
    .loadDoneIn(loadDoneLine), .loadDoneOut(loadDoneOut), .loadDoneOe(loadDoneOe),
    .initDoneOut(initDoneOut), .initDoneOe(initDoneOe), .dataUserIo(dataUserIo),
    .busWidth(busWidth), .ratioLog(ratioLog), .initDoneEn(initDoneEn),
    .userInitSel(userInitSel), .streamWords(streamWords), .cfgWord(cfgWord),
    .cfgWordValid(cfgWordValid), .cfgWordReady(cfgWordReady), .userMode(userMode),
    .loadError(loadError));
  // User clock, a sink that may stall, and the hang limit
  always @(posedge clk) begin
    ucDiv <= ucDiv + 3'h1;
    userInitClock <= ucDiv[2];
    cfgWordReady <= holdSink ? 1'b0 : (stallOn ? ~cfgWordReady : 1'b1);
    if (cfgWordValid === 1'b1 && cfgWordReady)
      got.push_back(cfgWord);
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares = miscompares + 1;
      tally_and_finish;
    end
  end
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    begin
      nCompared = nCompared + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("compared %0d mismatched %0d", nCompared, miscompares);
      if (miscompares == 0 && nCompared > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // Straps, restart, then words of alternating polarity
  task run_cfg(input [5:0] opt, input [31:0] d, input [23:0] nw);
    begin
      {busWidth, ratioLog, userInitSel, initDoneEn} <= opt;
      streamWords <= nw;
      got.delete();
      i_fpcl_host.restart;
      for (k = 0; k < nw; k = k + 1)
        i_fpcl_host.send(k[0] ? ~d : d, 4'h1 << opt[3:2]);
    end
  endtask
  task wait_user;
    begin
      k = 0;
      while (userMode !== 1'b1 && k < 3000) begin
        @(posedge clk);
        k = k + 1;
      end
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    check("ready oe", readyOe, 1);
    check("done oe", {loadDoneOe, cfgWordValid}, 2'h2);
    sys_rst <= 1'b0;
    repeat (10) @(posedge clk);
    check("ready in por", readyOe, 1);
    repeat (20) @(posedge clk);
    check("after por", {readyOe, loadDoneOe}, 2'h1);
    $display("reset test done");
    for (r = 0; r < 4; r = r + 1) begin
      row = rows[r];
      mask = row[69:68] == 2'h0 ? 32'h0000_00ff :
             row[69:68] == 2'h1 ? 32'h0000_ffff : 32'hffff_ffff;
      stallOn <= r[0];
      run_cfg(row[69:64], row[63:32], 24'h2);
      i_fpcl_host.finish(4'h1 << row[67:66]);
      wait_user;
      check("word 0", got[0], row[31:0]);
      check("word 1", got[1], ~row[63:32] & mask);
      check("word count", got.size(), 2);
      check("user mode", {userMode, dataUserIo, initDoneOe}, 3'h6);
      check("lines high", {readyLine, loadDoneLine}, 2'h3);
      i_fpcl_host.tick;
      i_fpcl_host.tick;
      check("clock ignored", {userMode, loadDoneLine}, 2'h3);
      $display("row %0d done", r);
    end
    // Sink held off so the buffer overruns
    holdSink <= 1'b1;
    run_cfg(6'h20, 32'h0f0f_0f0f, 24'h10);
    check("overflow", {loadError, readyOe, loadDoneOe}, 3'h7);
    holdSink <= 1'b0;
    repeat (20) @(posedge clk);
    run_cfg(6'h20, 32'h0f0f_0f0f, 24'h1);
    i_fpcl_host.finish(4'h1);
    wait_user;
    check("retry", got[0], 32'h0f0f_0f0f);
    check("retry user", userMode, 1);
    $display("overflow test done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    check("reset in use", {userMode, dataUserIo, initDoneOe, readyOe, loadDoneOe}, 5'h03);
    sys_rst <= 1'b0;
    repeat (10) @(posedge clk);
    check("por again", readyOe, 1);
    $display("mid-run reset test done");
    tally_and_finish;
  end
endmodule
